//--- shared/ifsb_defs.svh
/*
 flag status bank constants: register byte offsets, bit positions, implemented masks, reset values.
 assumes 32-bit AXI4-Lite word addressing with the 16-bit registers in the low half of each word.
*/
`ifndef IFSB_DEFS_SVH
`define IFSB_DEFS_SVH

`define IFSB_ADDR_W 4
`define IFSB_OFS_FLAGS0 4'h0
`define IFSB_OFS_FLAGS1 4'h4

`define IFSB_F0_CAPTURE_CH1 1
`define IFSB_F0_EXT_IRQ0 0

`define IFSB_F1_EXT_IRQ2 13
`define IFSB_F1_CAPTURE_CH8 7
`define IFSB_F1_CAPTURE_CH7 6
`define IFSB_F1_EXT_IRQ1 4
`define IFSB_F1_PIN_CHANGE 3
`define IFSB_F1_I2C_MASTER 1
`define IFSB_F1_I2C_SLAVE 0

`define IFSB_MASK0 16'h0003
`define IFSB_MASK1 16'h20db
`define IFSB_RESET0 16'h0000
`define IFSB_RESET1 16'h0000

`define IFSB_RESP_OKAY 2'h0
`define IFSB_RESP_SLVERR 2'h2

`endif

//--- shared/ifsb_pkg.sv
/*
 types for the flag status bank.
 assumes the constants header is compiled alongside.
*/
package ifsb_pkg;
   typedef struct packed {
      logic [15:0] flags0;
      logic [15:0] flags1;
      logic awHeld;
      logic awReady;
      logic [3:0] awAddr;
      logic wHeld;
      logic wReady;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [15:0] srcSync1;
      logic [15:0] srcSync2;
      logic [15:0] srcLast;
   } ifsb_state_t;
endpackage

//--- logic/ifsb_flag_bank.sv
/*
 interrupt flag status bank: two 16-bit flag registers behind an AXI4-Lite slave.
 assumes request lines are asynchronous levels; a rising edge records a request.
*/
`timescale 1ns/1ps
`include "ifsb_defs.svh"

module ifsb_flag_bank
   import ifsb_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic capture_ch1_req,
   input wire logic ext_irq0_req,
   input wire logic ext_irq1_req,
   input wire logic ext_irq2_req,
   input wire logic capture_ch7_req,
   input wire logic capture_ch8_req,
   input wire logic pin_change_req,
   input wire logic i2c_master_req,
   input wire logic i2c_slave_req,
   input wire logic [`IFSB_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`IFSB_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [15:0] interrupt_flags_0,
   output logic [15:0] interrupt_flags_1
);

   ////////////////////////////////////////////////////////////////////////////
   ifsb_state_t st_q;
   ifsb_state_t st_d;
   logic [15:0] srcRaw;
   logic [15:0] srcRise;
   logic [15:0] srcRise0;
   logic [15:0] srcRise1;
   logic wrFire;
   logic rdFire;

   function automatic logic [15:0] merge_strb(input logic [15:0] oldV, input logic [31:0] wd,
                                              input logic [3:0] strb, input logic [15:0] mask);
      logic [15:0] nv;
      nv = oldV;
      if (strb[0]) begin
         nv[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         nv[15:8] = wd[15:8];
      end
      merge_strb = nv & mask;
   endfunction

   // one decoder shared by the write and read paths so both always agree on the map
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_FLAGS0 = 2'h1;
   localparam logic [1:0] SEL_FLAGS1 = 2'h2;

   function automatic logic [1:0] reg_select(input logic [`IFSB_ADDR_W-1:0] addr);
      logic [1:0] sel;
      sel = SEL_NONE;
      if (addr == `IFSB_OFS_FLAGS0) begin
         sel = SEL_FLAGS0;
      end
      if (addr == `IFSB_OFS_FLAGS1) begin
         sel = SEL_FLAGS1;
      end
      reg_select = sel;
   endfunction

   // sources packed at their flags1 positions; bits 15:14 carry flags0 sources
   always_comb begin
      srcRaw = 16'h0000;
      srcRaw[15] = capture_ch1_req;
      srcRaw[14] = ext_irq0_req;
      srcRaw[`IFSB_F1_EXT_IRQ2] = ext_irq2_req;
      srcRaw[`IFSB_F1_CAPTURE_CH8] = capture_ch8_req;
      srcRaw[`IFSB_F1_CAPTURE_CH7] = capture_ch7_req;
      srcRaw[`IFSB_F1_EXT_IRQ1] = ext_irq1_req;
      srcRaw[`IFSB_F1_PIN_CHANGE] = pin_change_req;
      srcRaw[`IFSB_F1_I2C_MASTER] = i2c_master_req;
      srcRaw[`IFSB_F1_I2C_SLAVE] = i2c_slave_req;
   end

   // edge taken from the second sync stage only; the first feeds nothing else
   assign srcRise = st_q.srcSync2 & ~st_q.srcLast;
   always_comb begin
      srcRise0 = 16'h0000;
      srcRise0[`IFSB_F0_CAPTURE_CH1] = srcRise[15];
      srcRise0[`IFSB_F0_EXT_IRQ0] = srcRise[14];
      srcRise1 = srcRise & `IFSB_MASK1;
   end

   assign wrFire = st_q.awHeld && st_q.wHeld && !st_q.bValid;
   assign rdFire = s_axi_arvalid && st_q.arReady;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      st_d.srcSync1 = srcRaw;
      st_d.srcSync2 = st_q.srcSync1;
      st_d.srcLast = st_q.srcSync2;
      if (s_axi_awvalid && !st_q.awHeld) begin
         st_d.awHeld = 1'b1;
         st_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.wHeld) begin
         st_d.wHeld = 1'b1;
         st_d.wData = s_axi_wdata;
         st_d.wStrb = s_axi_wstrb;
      end
      // software write first, then hardware sets win over a same-cycle clear
      if (wrFire) begin
         st_d.awHeld = 1'b0;
         st_d.wHeld = 1'b0;
         st_d.bValid = 1'b1;
         st_d.bResp = `IFSB_RESP_OKAY;
         case (reg_select(st_q.awAddr))
            SEL_FLAGS0: begin
               st_d.flags0 = merge_strb(st_q.flags0, st_q.wData, st_q.wStrb, `IFSB_MASK0);
            end
            SEL_FLAGS1: begin
               st_d.flags1 = merge_strb(st_q.flags1, st_q.wData, st_q.wStrb, `IFSB_MASK1);
            end
            default: begin
               st_d.bResp = `IFSB_RESP_SLVERR;
            end
         endcase
      end
      st_d.flags0 = st_d.flags0 | srcRise0;
      st_d.flags1 = st_d.flags1 | srcRise1;
      if (st_q.bValid && s_axi_bready) begin
         st_d.bValid = 1'b0;
      end
      if (rdFire) begin
         st_d.arReady = 1'b0;
         st_d.rValid = 1'b1;
         st_d.rResp = `IFSB_RESP_OKAY;
         case (reg_select(s_axi_araddr))
            SEL_FLAGS0: begin
               st_d.rData = {16'h0000, st_q.flags0 & `IFSB_MASK0};
            end
            SEL_FLAGS1: begin
               st_d.rData = {16'h0000, st_q.flags1 & `IFSB_MASK1};
            end
            default: begin
               st_d.rData = 32'h00000000;
               st_d.rResp = `IFSB_RESP_SLVERR;
            end
         endcase
      end
      if (st_q.rValid && s_axi_rready) begin
         st_d.rValid = 1'b0;
         st_d.arReady = 1'b1;
      end
      // ready flops hold the inverse of the held flags so the bus sees a plain register
      st_d.awReady = !st_d.awHeld;
      st_d.wReady = !st_d.wHeld;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.flags0 <= `IFSB_RESET0;
         st_q.flags1 <= `IFSB_RESET1;
         st_q.arReady <= 1'b1;
         st_q.awReady <= 1'b1;
         st_q.wReady <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign s_axi_awready = st_q.awReady;
   assign s_axi_wready = st_q.wReady;
   assign s_axi_bvalid = st_q.bValid;
   assign s_axi_bresp = st_q.bResp;
   assign s_axi_arready = st_q.arReady;
   assign s_axi_rvalid = st_q.rValid;
   assign s_axi_rdata = st_q.rData;
   assign s_axi_rresp = st_q.rResp;
   assign interrupt_flags_0 = st_q.flags0;
   assign interrupt_flags_1 = st_q.flags1;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_RISE_SETS_FLAG1: assert property (@(posedge clk) disable iff (!reset_n)
      (srcRise1 != 16'h0000) |=> ((st_q.flags1 & $past(srcRise1)) == $past(srcRise1)))
      else $error("flags1 missed a request edge");
   AST_CH1_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      srcRise[15] |=> interrupt_flags_0[1])
      else $error("capture ch1 flag not at bit 1");
   AST_IRQ0_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      srcRise[14] |=> interrupt_flags_0[0])
      else $error("ext irq0 flag not at bit 0");
   AST_CH8_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(capture_ch8_req) ##1 capture_ch8_req [*2] |=> ##1 interrupt_flags_1[7])
      else $error("capture ch8 flag not set");
   AST_IRQ1_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      srcRise[4] |=> interrupt_flags_1[4])
      else $error("ext irq1 flag not at bit 4");
   AST_PINCHG_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      srcRise[3] |=> interrupt_flags_1[3])
      else $error("pin change flag not at bit 3");
   AST_I2CM_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      srcRise[1] |=> interrupt_flags_1[1])
      else $error("i2c master flag not at bit 1");
   AST_I2CS_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      srcRise[0] |=> interrupt_flags_1[0])
      else $error("i2c slave flag not at bit 0");
   AST_UNIMPL_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
      ((interrupt_flags_1 & ~`IFSB_MASK1) == 16'h0000) && ((interrupt_flags_0 & ~`IFSB_MASK0) == 16'h0000))
      else $error("unimplemented flag bit set");
   AST_IRQ2_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      srcRise[13] |=> interrupt_flags_1[13])
      else $error("ext irq2 flag not at bit 13");
   AST_SW_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
      (wrFire && st_q.awAddr == `IFSB_OFS_FLAGS1 && st_q.wStrb[0] && st_q.wData[0] == 1'b0 && !srcRise[0])
      |=> !interrupt_flags_1[0])
      else $error("software clear of flags1 bit 0 lost");
   AST_READ_ANSWER: assert property (@(posedge clk) disable iff (!reset_n)
      rdFire |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after address");
   AST_CH7_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      srcRise[6] |=> interrupt_flags_1[6])
      else $error("capture ch7 flag not at bit 6");
   AST_CH8_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      srcRise[7] |=> interrupt_flags_1[7])
      else $error("capture ch8 flag not at bit 7");
   AST_RISE_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
      (srcRise != 16'h0000) |=> ((srcRise & $past(srcRise)) == 16'h0000))
      else $error("a held request level raised a second edge");

   ////////////////////////////////////////////////////////////////////////////
   // request paths: pin rise to flag, through two sync stages and the edge detector
   AST_CH1_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(capture_ch1_req) ##1 capture_ch1_req [*2] |=> ##1 interrupt_flags_0[1])
      else $error("capture ch1 request did not reach its flag");
   AST_IRQ0_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(ext_irq0_req) ##1 ext_irq0_req [*2] |=> ##1 interrupt_flags_0[0])
      else $error("ext irq0 request did not reach its flag");
   AST_CH7_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(capture_ch7_req) ##1 capture_ch7_req [*2] |=> ##1 interrupt_flags_1[6])
      else $error("capture ch7 request did not reach its flag");
   AST_IRQ1_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(ext_irq1_req) ##1 ext_irq1_req [*2] |=> ##1 interrupt_flags_1[4])
      else $error("ext irq1 request did not reach its flag");
   AST_PINCHG_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(pin_change_req) ##1 pin_change_req [*2] |=> ##1 interrupt_flags_1[3])
      else $error("pin change request did not reach its flag");
   AST_I2CM_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(i2c_master_req) ##1 i2c_master_req [*2] |=> ##1 interrupt_flags_1[1])
      else $error("i2c master request did not reach its flag");
   AST_I2CS_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(i2c_slave_req) ##1 i2c_slave_req [*2] |=> ##1 interrupt_flags_1[0])
      else $error("i2c slave request did not reach its flag");
   AST_IRQ2_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(ext_irq2_req) ##1 ext_irq2_req [*2] |=> ##1 interrupt_flags_1[13])
      else $error("ext irq2 request did not reach its flag");

   ////////////////////////////////////////////////////////////////////////////
   // flag integrity: nothing sets a flag but a request edge or a write
   AST_NO_SPURIOUS0: assert property (@(posedge clk) disable iff (!reset_n)
      !wrFire |=> ((interrupt_flags_0 & ~$past(interrupt_flags_0) & ~$past(srcRise0)) == 16'h0000))
      else $error("flags0 bit set without a request");
   AST_NO_SPURIOUS1: assert property (@(posedge clk) disable iff (!reset_n)
      !wrFire |=> ((interrupt_flags_1 & ~$past(interrupt_flags_1) & ~$past(srcRise1)) == 16'h0000))
      else $error("flags1 bit set without a request");
   AST_FLAGS_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
      (!wrFire && (srcRise0 == 16'h0000) && (srcRise1 == 16'h0000)) |=> ($stable(interrupt_flags_0) && $stable(interrupt_flags_1)))
      else $error("flags changed with no request and no write");
   AST_RESET_CLEAR: assert property (@(posedge clk)
      $rose(reset_n) |-> ((interrupt_flags_0 == 16'h0000) && (interrupt_flags_1 == 16'h0000)))
      else $error("flags not clear after reset");
   AST_BAD_WRITE_KEEPS: assert property (@(posedge clk) disable iff (!reset_n)
      (wrFire && (reg_select(st_q.awAddr) == SEL_NONE)) |=>
      ((interrupt_flags_0 == ($past(interrupt_flags_0) | $past(srcRise0))) && (interrupt_flags_1 == ($past(interrupt_flags_1) | $past(srcRise1)))))
      else $error("unmapped write changed a flag");

   ////////////////////////////////////////////////////////////////////////////
   // register bus handshakes and answers
   AST_WRITE_ANSWER: assert property (@(posedge clk) disable iff (!reset_n)
      wrFire |=> s_axi_bvalid)
      else $error("write answer not one cycle after both channels held");
   AST_WRITE_OKAY: assert property (@(posedge clk) disable iff (!reset_n)
      (wrFire && (reg_select(st_q.awAddr) != SEL_NONE)) |=> (s_axi_bresp == `IFSB_RESP_OKAY))
      else $error("mapped write not answered okay");
   AST_BAD_WRITE_RESP: assert property (@(posedge clk) disable iff (!reset_n)
      (wrFire && (reg_select(st_q.awAddr) == SEL_NONE)) |=> (s_axi_bresp == `IFSB_RESP_SLVERR))
      else $error("unmapped write not answered with an error");
   AST_BVALID_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
      (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("write answer dropped before it was taken");
   AST_RVALID_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
      (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
      else $error("read answer dropped before it was taken");
   AST_AR_BLOCKED: assert property (@(posedge clk) disable iff (!reset_n)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while an answer is pending");
   AST_READ_FLAGS0: assert property (@(posedge clk) disable iff (!reset_n)
      (rdFire && (reg_select(s_axi_araddr) == SEL_FLAGS0)) |=>
      ((s_axi_rdata == {16'h0000, $past(interrupt_flags_0)}) && (s_axi_rresp == `IFSB_RESP_OKAY)))
      else $error("flags0 read does not return the register");
   AST_READ_FLAGS1: assert property (@(posedge clk) disable iff (!reset_n)
      (rdFire && (reg_select(s_axi_araddr) == SEL_FLAGS1)) |=>
      ((s_axi_rdata == {16'h0000, $past(interrupt_flags_1) & `IFSB_MASK1}) && (s_axi_rresp == `IFSB_RESP_OKAY)))
      else $error("flags1 read does not return the masked register");
   AST_BAD_READ: assert property (@(posedge clk) disable iff (!reset_n)
      (rdFire && (reg_select(s_axi_araddr) == SEL_NONE)) |=> ((s_axi_rresp == `IFSB_RESP_SLVERR) && (s_axi_rdata == 32'h00000000)))
      else $error("unmapped read not answered with an error");

   ////////////////////////////////////////////////////////////////////////////
   // main scenarios
   COV_READ: cover property (@(posedge clk) disable iff (!reset_n) rdFire);
   COV_WRITE: cover property (@(posedge clk) disable iff (!reset_n) wrFire);
   COV_SET_CLEAR: cover property (@(posedge clk) disable iff (!reset_n) wrFire && (srcRise != 16'h0000));
   COV_BAD_ADDR: cover property (@(posedge clk) disable iff (!reset_n) s_axi_bvalid && s_axi_bresp == `IFSB_RESP_SLVERR);
   COV_RESET_RELEASE: cover property (@(posedge clk) $rose(reset_n));

endmodule // ifsb_flag_bank

//--- verification/ifsb_source_model.sv
/*
 request sources standing in for the capture channels, external pins, pin change and i2c events.
 assumes one pulse on fire[i] starts one request; lines idle low between requests.
*/
`timescale 1ns/1ps
module ifsb_source_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [8:0] fire,
   output logic [8:0] req
);
   logic [8:0] stage0_q;
   logic [8:0] stage1_q;
   logic [8:0] stage2_q;
   logic [8:0] stage3_q;
   // request held four cycles so the two-flop sync on the far side cannot miss it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage0_q <= 9'h000;
         stage1_q <= 9'h000;
         stage2_q <= 9'h000;
         stage3_q <= 9'h000;
      end else begin
         stage0_q <= fire;
         stage1_q <= stage0_q;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end
   assign req = stage0_q | stage1_q | stage2_q | stage3_q;
endmodule // ifsb_source_model

//--- verification/ifsb_flag_bank_tb_top.sv
/*
 testbench for the flag status bank: axi4-lite register tasks and request stimulus.
 assumes the design's constants header and the source model are compiled alongside.
*/
`timescale 1ns/1ps
`include "ifsb_defs.svh"
module ifsb_flag_bank_tb_top;
   logic clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] bresp, rresp, resp;
   logic [8:0] fire = 9'h000, req;
   logic [15:0] flags0, flags1;
   int errTotal = 0, comparisons = 0;
   always #20 clk = ~clk;
   ifsb_source_model u_ifsb_source_model (.clk(clk), .reset_n(reset_n), .fire(fire), .req(req));
   ifsb_flag_bank u_ifsb_flag_bank (.clk(clk), .reset_n(reset_n), .capture_ch1_req(req[0]),
      .ext_irq0_req(req[1]), .ext_irq1_req(req[2]), .ext_irq2_req(req[3]), .capture_ch7_req(req[4]),
      .capture_ch8_req(req[5]), .pin_change_req(req[6]), .i2c_master_req(req[7]), .i2c_slave_req(req[8]),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .interrupt_flags_0(flags0), .interrupt_flags_1(flags1));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errTotal++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awready) begin
            awvalid <= 1'h0;
         end
         if (wvalid && wready) begin
            wvalid <= 1'h0;
         end
         if (bvalid) begin
            break;
         end
      end
      resp = bresp;
      bready <= 1'h0;
      if (n == 50) begin
         errTotal++;
         finish_test();
      end
   endtask
   task automatic rdr(input logic [3:0] a);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready) begin
            arvalid <= 1'h0;
         end
         if (rvalid) begin
            break;
         end
      end
      rd = rdata;
      resp = rresp;
      rready <= 1'h0;
      if (n == 50) begin
         errTotal++;
         finish_test();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   logic [3:0] regOfs [9] = '{`IFSB_OFS_FLAGS0, `IFSB_OFS_FLAGS0, `IFSB_OFS_FLAGS1, `IFSB_OFS_FLAGS1,
      `IFSB_OFS_FLAGS1, `IFSB_OFS_FLAGS1, `IFSB_OFS_FLAGS1, `IFSB_OFS_FLAGS1, `IFSB_OFS_FLAGS1};
   int bitPos [9] = '{`IFSB_F0_CAPTURE_CH1, `IFSB_F0_EXT_IRQ0, `IFSB_F1_EXT_IRQ1, `IFSB_F1_EXT_IRQ2,
      `IFSB_F1_CAPTURE_CH7, `IFSB_F1_CAPTURE_CH8, `IFSB_F1_PIN_CHANGE, `IFSB_F1_I2C_MASTER, `IFSB_F1_I2C_SLAVE};
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'h1;
      rdr(`IFSB_OFS_FLAGS0);
      chk(rd, 32'h0);
      rdr(`IFSB_OFS_FLAGS1);
      chk(rd, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         fire[i] <= 1'h1;
         @(posedge clk);
         fire[i] <= 1'h0;
         // flag lands three edges after the request rise; margin for the stretcher
         repeat (10) @(posedge clk);
         rdr(regOfs[i]);
         chk(rd, 32'h1 << bitPos[i]);
         chk({flags1, flags0}, (32'h1 << bitPos[i]) << ((regOfs[i] == `IFSB_OFS_FLAGS0) ? 0 : 16));
         wr(regOfs[i], 32'h0, 4'hf);
         chk(resp, `IFSB_RESP_OKAY);
         rdr(regOfs[i]);
         chk(rd, 32'h0);
      end
      $display("test request sources done");
      wr(`IFSB_OFS_FLAGS0, 32'hffffffff, 4'hf);
      rdr(`IFSB_OFS_FLAGS0);
      chk(rd, {16'h0, `IFSB_MASK0});
      wr(`IFSB_OFS_FLAGS1, 32'hffffffff, 4'hf);
      rdr(`IFSB_OFS_FLAGS1);
      chk(rd, 32'h000020db);
      wr(`IFSB_OFS_FLAGS1, 32'h0, 4'hf);
      rdr(`IFSB_OFS_FLAGS1);
      chk(rd, 32'h0);
      // byte strobes: only the lane whose strobe is set may change
      wr(`IFSB_OFS_FLAGS1, 32'hffffffff, 4'h2);
      rdr(`IFSB_OFS_FLAGS1);
      chk(rd, 32'h1 << `IFSB_F1_EXT_IRQ2);
      wr(`IFSB_OFS_FLAGS1, 32'hffffffff, 4'h1);
      rdr(`IFSB_OFS_FLAGS1);
      chk(rd, 32'h000020db);
      $display("test software access done");
      wr(`IFSB_OFS_FLAGS0, 32'hffffffff, 4'hf);
      @(posedge clk);
      reset_n <= 1'h0;
      repeat (4) @(posedge clk);
      reset_n <= 1'h1;
      chk({flags1, flags0}, 32'h0);
      rdr(`IFSB_OFS_FLAGS0);
      chk(rd, 32'h0);
      rdr(`IFSB_OFS_FLAGS1);
      chk(rd, 32'h0);
      $display("test mid-run reset done");
      wr(4'hc, 32'hffffffff, 4'hf);
      chk(resp, `IFSB_RESP_SLVERR);
      rdr(4'h8);
      chk(resp, `IFSB_RESP_SLVERR);
      chk(rd, 32'h0);
      rdr(`IFSB_OFS_FLAGS1);
      chk(rd, 32'h0);
      $display("test unmapped access done");
      finish_test();
   end
endmodule // ifsb_flag_bank_tb_top
